/* hdl/ccst_cfg.svh */
// offsets, field positions, reset values and timing counts of the calendar clock
`ifndef CCST_CFG_SVH
`define CCST_CFG_SVH

// register indices; byte address is four times the index
`define CCST_IDX_SEC     14'h2015
`define CCST_IDX_MIN     14'h2016
`define CCST_IDX_HOUR    14'h2017
`define CCST_IDX_WDAY    14'h2018
`define CCST_IDX_DATE    14'h2019
`define CCST_IDX_MONTH   14'h201a
`define CCST_IDX_YEAR    14'h201b
`define CCST_IDX_TRIM    14'h201c

// trim strobe bit positions
`define CCST_ADD_BIT     0
`define CCST_DROP_BIT    1

// reset values
`define CCST_RST_SEC     6'h00
`define CCST_RST_MIN     6'h00
`define CCST_RST_HOUR    5'h00
`define CCST_RST_WDAY    3'h1
`define CCST_RST_DATE    5'h01
`define CCST_RST_MONTH   4'h1
`define CCST_RST_YEAR    8'h00

// field limits
`define CCST_SEC_MAX     6'h3b
`define CCST_MIN_MAX     6'h3b
`define CCST_HOUR_MAX    5'h17
`define CCST_WDAY_MIN    3'h1
`define CCST_WDAY_MAX    3'h7
`define CCST_DATE_MIN    5'h01
`define CCST_MONTH_MIN   4'h1
`define CCST_MONTH_MAX   4'hc
`define CCST_FEB         4'h2

// timing
`define CCST_CLK_NS      10
`define CCST_SEC_NS      1000000000
`define CCST_SEC_CYCLES  (`CCST_SEC_NS / `CCST_CLK_NS)

`endif

/* hdl/ccst_pkg.sv */
// types shared by the calendar clock
package ccst_pkg;

  typedef struct packed {
    logic [7:0] year;
    logic [3:0] month;
    logic [4:0] date;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } ccst_time_t;

  typedef enum logic [1:0] {
    CCST_STEP_NORMAL,
    CCST_STEP_ADD,
    CCST_STEP_DROP
  } ccst_step_t;

endpackage

/* hdl/ccst_top.sv */
// calendar clock with second trim, apb register slave
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ccst_cfg.svh"

module ccst_top #(
  parameter int unsigned SEC_CYCLES = `CCST_SEC_CYCLES
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [15:0]      paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic                  second_tick,
  output logic [5:0]            seconds_field,
  output logic [5:0]            minutes_field,
  output logic [4:0]            hours_field,
  output logic [2:0]            weekday_field,
  output logic [4:0]            day_of_month_field,
  output logic [3:0]            month_field,
  output logic [7:0]            year_field,
  output ccst_pkg::ccst_time_t  time_now
);
  import ccst_pkg::*;

  localparam int CW = $clog2(SEC_CYCLES + 1);
  localparam logic [CW-1:0] DIV_LAST = CW'(SEC_CYCLES - 1);

  // days in a month; year zero and every fourth year are leap
  function automatic logic [4:0] days_in(
    input logic [3:0] month,
    input logic [7:0] year
  );
    logic leap;
    leap = (year[1:0] == 2'b00);
    unique case (month)
      4'h4, 4'h6, 4'h9, 4'hb: days_in = 5'h1e;
      `CCST_FEB:               days_in = leap ? 5'h1d : 5'h1c;
      default:                 days_in = 5'h1f;
    endcase
  endfunction

  // one second of calendar advance with carries
  function automatic ccst_time_t advance(input ccst_time_t t);
    ccst_time_t r;
    logic       c_min;
    logic       c_hour;
    logic       c_day;
    logic       c_month;
    r       = t;
    c_min   = (t.sec >= `CCST_SEC_MAX);
    c_hour  = c_min & (t.min >= `CCST_MIN_MAX);
    c_day   = c_hour & (t.hour >= `CCST_HOUR_MAX);
    c_month = c_day & (t.date >= days_in(t.month, t.year));
    // compare with >= so a bad written value still wraps
    r.sec   = c_min ? 6'h00 : t.sec + 6'h01;
    if (c_min) begin
      r.min = (t.min >= `CCST_MIN_MAX) ? 6'h00 : t.min + 6'h01;
    end
    if (c_hour) begin
      r.hour = (t.hour >= `CCST_HOUR_MAX) ? 5'h00 : t.hour + 5'h01;
    end
    if (c_day) begin
      r.wday = (t.wday >= `CCST_WDAY_MAX || t.wday < `CCST_WDAY_MIN) ?
               `CCST_WDAY_MIN : t.wday + 3'h1;
      r.date = c_month ? `CCST_DATE_MIN : t.date + 5'h01;
    end
    if (c_month) begin
      r.month = (t.month >= `CCST_MONTH_MAX) ?
                `CCST_MONTH_MIN : t.month + 4'h1;
      if (t.month >= `CCST_MONTH_MAX) begin
        r.year = t.year + 8'h01;
      end
    end
    return r;
  endfunction

  // one aligned word per register
  function automatic logic reg_hit(
    input logic [15:0] addr,
    input logic [13:0] index
  );
    return (addr[1:0] == 2'b00) && (addr[15:2] == index);
  endfunction

  // field in the low bits, upper bits zero; trim reads as zero
  function automatic logic [31:0] read_word(
    input ccst_time_t  t,
    input logic [13:0] index
  );
    logic [31:0] w;
    w = 32'h0;
    case (index)
      `CCST_IDX_SEC:   w = {26'h0, t.sec};
      `CCST_IDX_MIN:   w = {26'h0, t.min};
      `CCST_IDX_HOUR:  w = {27'h0, t.hour};
      `CCST_IDX_WDAY:  w = {29'h0, t.wday};
      `CCST_IDX_DATE:  w = {27'h0, t.date};
      `CCST_IDX_MONTH: w = {28'h0, t.month};
      `CCST_IDX_YEAR:  w = {24'h0, t.year};
      default:         w = 32'h0;
    endcase
    return w;
  endfunction

  // reset release through two flops
  logic rst_a_ff;
  logic rst_n_ff;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_a_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_n_ff <= rst_a_ff;
    end
  end

  // apb decode
  wire [13:0] idx       = paddr[15:2];
  wire        aligned   = (paddr[1:0] == 2'b00);
  wire        setup     = psel & ~penable;
  wire        access    = psel & penable;
  wire        hit_sec   = reg_hit(paddr, `CCST_IDX_SEC);
  wire        hit_min   = reg_hit(paddr, `CCST_IDX_MIN);
  wire        hit_hour  = reg_hit(paddr, `CCST_IDX_HOUR);
  wire        hit_wday  = reg_hit(paddr, `CCST_IDX_WDAY);
  wire        hit_date  = reg_hit(paddr, `CCST_IDX_DATE);
  wire        hit_month = reg_hit(paddr, `CCST_IDX_MONTH);
  wire        hit_year  = reg_hit(paddr, `CCST_IDX_YEAR);
  wire        hit_trim  = reg_hit(paddr, `CCST_IDX_TRIM);
  wire        hit_time  = hit_sec | hit_min | hit_hour | hit_wday |
                          hit_date | hit_month | hit_year;
  wire        hit_any   = hit_time | hit_trim;
  wire        wr_go     = access & pwrite & pstrb[0] & hit_any;

  // zero wait states; unmapped and misaligned answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  // field writes
  wire wr_sec   = wr_go & hit_sec;
  wire wr_min   = wr_go & hit_min;
  wire wr_hour  = wr_go & hit_hour;
  wire wr_wday  = wr_go & hit_wday;
  wire wr_date  = wr_go & hit_date;
  wire wr_month = wr_go & hit_month;
  wire wr_year  = wr_go & hit_year;
  wire wr_trim  = wr_go & hit_trim;

  // trim strobes: both at once is ignored, software keeps them apart
  wire add_req  = wr_trim & pwdata[`CCST_ADD_BIT] & ~pwdata[`CCST_DROP_BIT];
  wire drop_req = wr_trim & pwdata[`CCST_DROP_BIT] & ~pwdata[`CCST_ADD_BIT];

  // seconds divider
  logic [CW-1:0] div_ff;
  logic          tick_ff;
  wire           div_end = (div_ff >= DIV_LAST);
  // writing seconds restarts the second so the new value lasts a full second
  wire [CW-1:0]  nxt_div = (div_end | wr_sec) ? '0 : div_ff + CW'(1);
  wire           tick    = div_end & ~wr_sec;

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // the pulse leaves one cycle after the step so the fields have settled
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= tick;
    end
  end

  // pending trim requests
  logic add_pend_ff;
  logic drop_pend_ff;

  // a request landing on the tick cycle is kept for the next tick
  wire nxt_add_pend  = add_req | (add_pend_ff & ~tick);
  wire nxt_drop_pend = drop_req | (drop_pend_ff & ~tick);

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      add_pend_ff <= 1'b0;
    end else begin
      add_pend_ff <= nxt_add_pend;
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      drop_pend_ff <= 1'b0;
    end else begin
      drop_pend_ff <= nxt_drop_pend;
    end
  end

  // step selection at the tick
  // drop wins if both ever pend; software keeps them apart
  ccst_step_t step;
  assign step = drop_pend_ff ? CCST_STEP_DROP :
                add_pend_ff  ? CCST_STEP_ADD  : CCST_STEP_NORMAL;

  // time keeping
  ccst_time_t time_ff;
  ccst_time_t adv1;
  ccst_time_t adv2;
  ccst_time_t stepped;
  ccst_time_t nxt_time;

  assign adv1 = advance(time_ff);
  assign adv2 = advance(adv1);

  always_comb begin
    stepped = time_ff;
    if (tick) begin
      unique case (step)
        CCST_STEP_NORMAL: stepped = adv1;
        CCST_STEP_ADD:    stepped = adv2;
        CCST_STEP_DROP:   stepped = time_ff;
      endcase
    end
  end

  // a written field overrides the tick in the same cycle
  always_comb begin
    nxt_time = stepped;
    if (wr_sec) begin
      nxt_time.sec = pwdata[5:0];
    end
    if (wr_min) begin
      nxt_time.min = pwdata[5:0];
    end
    if (wr_hour) begin
      nxt_time.hour = pwdata[4:0];
    end
    if (wr_wday) begin
      nxt_time.wday = pwdata[2:0];
    end
    if (wr_date) begin
      nxt_time.date = pwdata[4:0];
    end
    if (wr_month) begin
      nxt_time.month = pwdata[3:0];
    end
    if (wr_year) begin
      nxt_time.year = pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      time_ff.sec   <= `CCST_RST_SEC;
      time_ff.min   <= `CCST_RST_MIN;
      time_ff.hour  <= `CCST_RST_HOUR;
      time_ff.wday  <= `CCST_RST_WDAY;
      time_ff.date  <= `CCST_RST_DATE;
      time_ff.month <= `CCST_RST_MONTH;
      time_ff.year  <= `CCST_RST_YEAR;
    end else begin
      time_ff <= nxt_time;
    end
  end

  // read data, captured in the setup phase so it comes from a flop
  // a tick at the access edge shows only in the next read
  wire [31:0] rd_mux = aligned ? read_word(time_ff, idx) : 32'h0;

  logic [31:0] rdata_ff;
  wire  [31:0] nxt_rdata = (setup & ~pwrite) ? rd_mux : rdata_ff;

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs
  assign prdata             = rdata_ff;
  assign second_tick        = tick_ff;
  assign time_now           = time_ff;
  assign seconds_field      = time_ff.sec;
  assign minutes_field      = time_ff.min;
  assign hours_field        = time_ff.hour;
  assign weekday_field      = time_ff.wday;
  assign day_of_month_field = time_ff.date;
  assign month_field        = time_ff.month;
  assign year_field         = time_ff.year;

endmodule

`default_nettype wire

/* tb/ccst_assertions.sv */
// port assertions for the calendar clock
`timescale 1ns/1ps
`default_nettype none
module ccst_chk #(
  parameter int unsigned SEC_CYCLES = 20
) (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [15:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        second_tick,
  input wire logic [5:0]  seconds_field,
  input wire logic [5:0]  minutes_field,
  input wire logic [4:0]  hours_field,
  input wire logic [2:0]  weekday_field,
  input wire logic [4:0]  day_of_month_field,
  input wire logic [3:0]  month_field,
  input wire logic [7:0]  year_field
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // a bus access in the tick cycle may override a stepped field
  wire acc = psel && penable;
  property p_hour;
    second_tick && !$past(acc) && hours_field != $past(hours_field)
      |-> hours_field == ($past(hours_field) == 5'h17 ? 5'h00 : $past(hours_field) + 5'h01);
  endproperty
  a_hour: assert property (p_hour) else $error("hour step wrong");
  property p_wday;
    second_tick && !$past(acc) && weekday_field != $past(weekday_field)
      |-> weekday_field == ($past(weekday_field) == 3'h7 ? 3'h1 : $past(weekday_field) + 3'h1);
  endproperty
  a_wday: assert property (p_wday) else $error("weekday step wrong");
  property p_min;
    second_tick && !$past(acc) && minutes_field != $past(minutes_field)
      |-> minutes_field == ($past(minutes_field) == 6'h3b ? 6'h00 : $past(minutes_field) + 6'h01);
  endproperty
  a_min: assert property (p_min) else $error("minute step wrong");
  property p_carry;
    second_tick && !$past(acc) && minutes_field != $past(minutes_field)
      |-> $past(seconds_field) >= 6'h3a && seconds_field <= 6'h01;
  endproperty
  a_carry: assert property (p_carry) else $error("seconds carry wrong");
  property p_date;
    second_tick && !$past(acc) && day_of_month_field != $past(day_of_month_field)
      |-> hours_field == 5'h00 && (day_of_month_field == 5'h01
          || day_of_month_field == $past(day_of_month_field) + 5'h01);
  endproperty
  a_date: assert property (p_date) else $error("date step wrong");
  property p_feb;
    second_tick && !$past(acc) && $past(month_field) == 4'h2 && month_field != 4'h2
      |-> $past(day_of_month_field) == ($past(year_field[1:0]) == 2'b00 ? 5'h1d : 5'h1c);
  endproperty
  a_feb: assert property (p_feb) else $error("february length wrong");
  property p_set;
    acc && pwrite && pstrb[0] && paddr == 16'h8058 |=> minutes_field == $past(pwdata[5:0]);
  endproperty
  a_set: assert property (p_set) else $error("minute write lost");
  property p_trim_rd;
    psel && !penable && !pwrite && paddr == 16'h8070 |=> prdata == 32'h0;
  endproperty
  a_trim_rd: assert property (p_trim_rd) else $error("trim read not zero");
  c_midnight: cover property (second_tick && hours_field == 5'h00 && minutes_field == 6'h00);
  c_trim: cover property (acc && pwrite && paddr == 16'h8070);
  c_newmonth: cover property (second_tick && day_of_month_field == 5'h01);
endmodule
`default_nettype wire

/* tb/calendar_clock_with_second_trim_test.sv */
// random and corner bench for the calendar clock
`timescale 1ns/1ps
`default_nettype none
`include "ccst_cfg.svh"
module calendar_clock_with_second_trim_test;
  import ccst_pkg::*;
  logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, on = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rng = 32'he680;
  logic [3:0]  pstrb = 4'hf;
  logic [1:0]  trim = 0;
  logic        pready, pslverr, second_tick;
  logic [5:0]  sec_f, min_f;
  logic [4:0]  hour_f, date_f;
  logic [3:0]  mon_f;
  logic [2:0]  wday_f;
  logic [7:0]  year_f;
  ccst_time_t  time_now, mdl;
  int          fails = 0, check_count = 0;
  always #5 clock = ~clock;
  ccst_top #(.SEC_CYCLES(20)) i_ccst_top (.clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .second_tick(second_tick), .seconds_field(sec_f), .minutes_field(min_f),
    .hours_field(hour_f), .weekday_field(wday_f), .day_of_month_field(date_f), .month_field(mon_f),
    .year_field(year_f), .time_now(time_now));
  task automatic summarize;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic ccst_time_t step(input ccst_time_t t);
    logic [4:0] dim;
    dim = (t.month == 4'h2) ? ((t.year[1:0] == 2'b00) ? 5'h1d : 5'h1c)
        : (t.month inside {4'h4, 4'h6, 4'h9, 4'hb}) ? 5'h1e : 5'h1f;
    if (t.sec == 6'h3b) begin
      t.sec = 6'h00;
      if (t.min == 6'h3b) begin
        t.min = 6'h00;
        if (t.hour == 5'h17) begin
          t.hour = 5'h00;
          t.wday = (t.wday == 3'h7) ? 3'h1 : t.wday + 3'h1;
          if (t.date == dim) begin
            t.date = 5'h01;
            t.month = (t.month == 4'hc) ? 4'h1 : t.month + 4'h1;
            if (t.month == 4'h1) t.year++;
          end else t.date++;
        end else t.hour++;
      end else t.min++;
    end else t.sec++;
    return t;
  endfunction
  // waits for pready; only the watchdog ends a hung access
  task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic wait_tick;
    do @(posedge clock); while (second_tick !== 1'b1);
  endtask
  always @(posedge clock) if (on && second_tick === 1'b1) begin
    if (trim != 2'b10) mdl = step(mdl);
    if (trim == 2'b01) mdl = step(mdl);
    trim = 2'b00;
    chk(time_now, mdl);
    chk({year_f, mon_f, date_f, wday_f, hour_f, min_f, sec_f}, mdl);
  end
  initial begin
    #200000;
    fails++;
    summarize();
  end
  initial begin
    ccst_time_t  t;
    logic [31:0] r;
    logic        e;
    repeat (4) @(posedge clock);
    resetn <= 1;
    repeat (3) @(posedge clock);
    t = {`CCST_RST_YEAR, `CCST_RST_MONTH, `CCST_RST_DATE, `CCST_RST_WDAY,
         `CCST_RST_HOUR, `CCST_RST_MIN, `CCST_RST_SEC};
    chk(time_now, t);
    for (int i = 0; i < 12; i++) begin
      t = '{year: 8'(xs()), month: 4'(xs() % 12 + 1), date: 5'(xs() % 28 + 1), wday: 3'(xs() % 7 + 1),
            hour: 5'(xs() % 24), min: 6'(xs() % 60), sec: 6'(xs() % 60)};
      // day ends two seconds before midnight; cases 1 to 3 also end the month, case 0 is the leap February 28
      if (i < 4) {t.hour, t.min, t.sec, t.wday} = {5'h17, 6'h3b, 6'h3a, 3'h7};
      case (i)
        0: {t.year, t.month, t.date} = {8'h00, 4'h2, 5'h1c};
        1: {t.year, t.month, t.date} = {8'h01, 4'h2, 5'h1c};
        2: {t.year, t.month, t.date} = {8'hff, 4'hc, 5'h1f};
        3: {t.year, t.month, t.date} = {8'h04, 4'h4, 5'h1e};
        default: ;
      endcase
      // seconds first: it restarts the divider, so the rest lands before a tick
      wait_tick();
      bus(16'h8054, 1, 32'(t.sec), r, e);
      bus(16'h8058, 1, 32'(t.min), r, e);
      bus(16'h805c, 1, 32'(t.hour), r, e);
      bus(16'h8060, 1, 32'(t.wday), r, e);
      bus(16'h8064, 1, 32'(t.date), r, e);
      bus(16'h8068, 1, 32'(t.month), r, e);
      bus(16'h806c, 1, 32'(t.year), r, e);
      mdl = t;
      on = 1;
      wait_tick();
      wait_tick();
      bus(16'h8058, 0, 0, r, e);
      chk(r, 32'(mdl.min));
      chk(e, 1'b0);
      bus(16'h8070, 1, i[0] ? 32'h2 : 32'h1, r, e);
      if (i % 4 == 0) bus(16'h8070, 1, 32'h1, r, e);
      trim = i[0] ? 2'b10 : 2'b01;
      chk(time_now, mdl);
      repeat (3) wait_tick();
    end
    bus(16'h8070, 0, 0, r, e);
    chk(r, 0);
    bus(16'h8074, 0, 0, r, e);
    chk({r, 31'h0, e}, 64'h1);
    summarize();
  end
endmodule
bind ccst_top ccst_chk #(.SEC_CYCLES(SEC_CYCLES)) i_ccst_chk (.clock(clock), .resetn(resetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .second_tick(second_tick), .seconds_field(seconds_field), .minutes_field(minutes_field),
  .hours_field(hours_field), .weekday_field(weekday_field), .day_of_month_field(day_of_month_field),
  .month_field(month_field), .year_field(year_field));
`default_nettype wire
